// ### hdl/spp_code_field.sv
/*
 * One volatile bit-field code with saturating increment.
 * Assumes fuse_bits come from a nonvolatile fuse macro outside.
 */
`timescale 1ns/1ps
module spp_code_field #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         clk_en,
    input  wire logic         inc,
    input  wire logic [W-1:0] fuse_bits,
    output logic      [W-1:0] code_ff,
    output logic      [W-1:0] value_ff
);
    initial begin
        if (W < 1 || W > spp_pkg::FMAX_W)
            $error("field width out of range");
    end

    // Power cycle clears the volatile code only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            code_ff <= '0;
        end else if (clk_en && inc && code_ff != {W{1'b1}}) begin
            code_ff <= code_ff + 1'b1;
        end
    end

    // Blown bits show from the first enabled clock after reset, whatever the code
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            value_ff <= '0;
        end else if (clk_en) begin
            value_ff <= code_ff | fuse_bits;
        end
    end
endmodule : spp_code_field

// ### hdl/spp_pkg.sv
/*
 * Constants, codes and types of the supply pulse programming logic.
 * Assumes a 125 MHz core clock and a classified supply level input.
 */
package spp_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ           = 125;
    localparam int BURN_TIME_US      = 40;
    localparam int BURN_CYC_DFLT     = BURN_TIME_US * CLK_MHZ;
    localparam int HCNT_W            = 13;

    // ------------------------------------------------------------
    // Supply level symbols
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SPP_LVL_LOW = 2'h0,
        SPP_LVL_MID = 2'h1,
        SPP_LVL_TOP = 2'h2
    } spp_lvl_t;

    // ------------------------------------------------------------
    // Keys and field indices
    // ------------------------------------------------------------
    localparam logic [3:0] KEY_MODE_BLOW = 4'h1;
    localparam logic [3:0] KEY_MODE_TRY  = 4'h2;
    localparam logic [3:0] KEY_SENS      = 4'h1;
    localparam logic [3:0] KEY_DUTY      = 4'h2;
    localparam logic [3:0] KEY_CARR      = 4'h3;
    localparam logic [3:0] KEY_LOCK      = 4'h6;
    localparam int         NFIELD        = 4;
    localparam int         FMAX_W        = 8;
    localparam logic [1:0] IDX_SENS      = 2'h0;
    localparam logic [1:0] IDX_DUTY      = 2'h1;
    localparam logic [1:0] IDX_CARR      = 2'h2;
    localparam logic [1:0] IDX_LOCK      = 2'h3;

    // ------------------------------------------------------------
    // Programming states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        SPP_ST_WAIT = 5'h01,
        SPP_ST_MODE = 5'h02,
        SPP_ST_REG  = 5'h04,
        SPP_ST_ADDR = 5'h08,
        SPP_ST_HOLD = 5'h10
    } spp_state_t;

    // ------------------------------------------------------------
    // APB register map
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_CODE0   = 8'h08;
    localparam int          CTRL_PROG   = 0;
    localparam int          CTRL_BURN   = 1;
    localparam logic [1:0]  CTRL_RST    = 2'h3;
endpackage : spp_pkg

// ### hdl/spp_prog_core.sv
/*
 * Supply pulse programming logic: key decoding, addressing, fuse burn
 * requests and an APB register view.
 * Assumes rst_b follows the supply (power-on reset), level_sym comes
 * from a comparator front end, and fuses live in an outside macro that
 * blows burn_mask bits of burn_field on burn_req and reports them back.
 */
// Operation
// - Mid pulses between framing top pulses are counted as the key.
// - Keys are binary numbers; key one is register bit zero.
// - Codes are binary numbers; code one is field bit zero.
// - Mode key one selects burn and lock, key two trial.
// - Keys 1,2,3,6 select sensitivity, duty, carrier, lock.
// - Top pulse after register selection enters addressing state.
// - Each mid pulse falling edge increments the selected code.
// - Code saturates at field maximum, never wraps.
// - Code drives the internal DAC value output.
// - Code is volatile until fuses are blown.
// - Power cycle clears every unblown location.
// - Blown fuse bits stay set forever.
// - Top pulse of 40 us or more burns the addressed fuse.
// - Trial settings vanish on power cycle.
// - In trial mode top pulses cycle mode, register, addressing.
// - Duty field is eight bits, codes up to 255.
// - After lock fuse, all programming is ignored.
`timescale 1ns/1ps
module spp_prog_core #(
    parameter int BURN_CYC = spp_pkg::BURN_CYC_DFLT,
    parameter int SENS_W   = 8,
    parameter int DUTY_W   = 8,
    parameter int CARR_W   = 4
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic [1:0]  level_sym,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  fuse_sens,
    input  wire logic [7:0]  fuse_duty,
    input  wire logic [7:0]  fuse_carr,
    input  wire logic        fuse_lock,
    output logic      [7:0]  sens_dac,
    output logic      [7:0]  duty_dac,
    output logic      [7:0]  carr_dac,
    output logic             locked,
    output logic             burn_req,
    output logic      [1:0]  burn_field,
    output logic      [7:0]  burn_mask
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    initial begin
        if (DUTY_W != 8)
            $error("duty field must be eight bits");
        if (SENS_W < 1 || SENS_W > 8 || CARR_W < 1 || CARR_W > 8)
            $error("field width out of range");
    end

    localparam int FW [spp_pkg::NFIELD] = '{SENS_W, DUTY_W, CARR_W, 1};

    // ------------------------------------------------------------
    // Pulse events
    // ------------------------------------------------------------
    spp_pulse_if pev ();

    spp_pulse_det #(
        .BURN_CYC (BURN_CYC)
    ) u_det (
        .clk       (clk),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .level_sym (level_sym),
        .ev        (pev)
    );

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    spp_pkg::spp_state_t st_ff;
    logic [3:0]          key_ff;
    logic                try_ff;
    logic [1:0]          sel_ff;
    logic [1:0]          ctrl_ff;
    logic                burn_req_ff;
    logic [1:0]          burn_field_ff;
    logic [7:0]          burn_mask_ff;
    logic [1:0]          nxt_sel;
    logic                key_ok;
    logic                act;
    logic [7:0]          fuse_pad [spp_pkg::NFIELD];
    logic [7:0]          code_pad [spp_pkg::NFIELD];
    logic [7:0]          val_pad  [spp_pkg::NFIELD];

    assign locked = fuse_lock;
    // Lock fuse or software disable freezes the whole sequencer
    assign act = ctrl_ff[spp_pkg::CTRL_PROG] && !fuse_lock;

    assign fuse_pad[0] = fuse_sens;
    assign fuse_pad[1] = fuse_duty;
    assign fuse_pad[2] = fuse_carr;
    assign fuse_pad[3] = {7'h00, fuse_lock};

    // Register key to field index
    always_comb begin
        key_ok  = 1'b1;
        nxt_sel = spp_pkg::IDX_SENS;
        unique case (key_ff)
            spp_pkg::KEY_SENS: nxt_sel = spp_pkg::IDX_SENS;
            spp_pkg::KEY_DUTY: nxt_sel = spp_pkg::IDX_DUTY;
            spp_pkg::KEY_CARR: nxt_sel = spp_pkg::IDX_CARR;
            spp_pkg::KEY_LOCK: nxt_sel = spp_pkg::IDX_LOCK;
            default:           key_ok  = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff  <= spp_pkg::SPP_ST_WAIT;
            key_ff <= 4'h0;
            try_ff <= 1'b0;
            sel_ff <= spp_pkg::IDX_SENS;
        end else if (clk_en && act) begin
            unique case (st_ff)
                spp_pkg::SPP_ST_WAIT: begin
                    if (pev.top_end) begin
                        st_ff  <= spp_pkg::SPP_ST_MODE;
                        key_ff <= 4'h0;
                    end
                end
                spp_pkg::SPP_ST_MODE: begin
                    if (pev.top_end) begin
                        key_ff <= 4'h0;
                        // Unknown mode key drops back to wait
                        if (key_ff == spp_pkg::KEY_MODE_BLOW) begin
                            try_ff <= 1'b0;
                            st_ff  <= spp_pkg::SPP_ST_REG;
                        end else if (key_ff == spp_pkg::KEY_MODE_TRY) begin
                            try_ff <= 1'b1;
                            st_ff  <= spp_pkg::SPP_ST_REG;
                        end else begin
                            st_ff  <= spp_pkg::SPP_ST_WAIT;
                        end
                    end else if (pev.mid_fall && key_ff != 4'hF) begin
                        key_ff <= key_ff + 1'b1;
                    end
                end
                spp_pkg::SPP_ST_REG: begin
                    if (pev.top_end) begin
                        key_ff <= 4'h0;
                        sel_ff <= nxt_sel;
                        st_ff  <= key_ok ? spp_pkg::SPP_ST_ADDR
                                         : spp_pkg::SPP_ST_WAIT;
                    end else if (pev.mid_fall && key_ff != 4'hF) begin
                        key_ff <= key_ff + 1'b1;
                    end
                end
                spp_pkg::SPP_ST_ADDR: begin
                    // A burn ends the session until the next power cycle
                    if (pev.top_end && pev.top_long && !try_ff) begin
                        st_ff <= spp_pkg::SPP_ST_HOLD;
                    end else if (pev.top_end) begin
                        st_ff <= spp_pkg::SPP_ST_MODE;
                    end
                end
                spp_pkg::SPP_ST_HOLD: begin
                    st_ff <= spp_pkg::SPP_ST_HOLD;
                end
                default: begin
                    st_ff <= spp_pkg::SPP_ST_WAIT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Code fields
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < spp_pkg::NFIELD; i++) begin : g_fld
            logic [FW[i]-1:0] code_w;
            logic [FW[i]-1:0] val_w;
            logic             inc_w;

            assign inc_w = act && pev.mid_fall && st_ff == spp_pkg::SPP_ST_ADDR
                           && sel_ff == 2'(i);

            spp_code_field #(
                .W (FW[i])
            ) u_fld (
                .clk       (clk),
                .rst_b     (rst_b),
                .clk_en    (clk_en),
                .inc       (inc_w),
                .fuse_bits (fuse_pad[i][FW[i]-1:0]),
                .code_ff   (code_w),
                .value_ff  (val_w)
            );

            assign code_pad[i] = 8'(code_w);
            assign val_pad[i]  = 8'(val_w);
        end
    endgenerate

    assign sens_dac = val_pad[0];
    assign duty_dac = val_pad[1];
    assign carr_dac = val_pad[2];

    // ------------------------------------------------------------
    // Fuse burn request
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            burn_req_ff   <= 1'b0;
            burn_field_ff <= spp_pkg::IDX_SENS;
            burn_mask_ff  <= 8'h00;
        end else if (clk_en) begin
            burn_req_ff <= act && ctrl_ff[spp_pkg::CTRL_BURN] && !try_ff
                           && st_ff == spp_pkg::SPP_ST_ADDR
                           && pev.top_end && pev.top_long;
            if (st_ff == spp_pkg::SPP_ST_ADDR) begin
                burn_field_ff <= sel_ff;
                burn_mask_ff  <= code_pad[sel_ff];
            end
        end
    end

    assign burn_req   = burn_req_ff;
    assign burn_field = burn_field_ff;
    assign burn_mask  = burn_mask_ff;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic        wr_acc;
    logic        rd_hit;
    logic [31:0] rd_mux;
    logic [7:0]  fld_off;

    // Below the first field the subtraction wraps high and misses the window
    assign fld_off = paddr - spp_pkg::OFS_CODE0;

    // Zero wait states; every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_acc = psel && penable && pwrite;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= spp_pkg::CTRL_RST;
        end else if (clk_en && wr_acc && paddr == spp_pkg::OFS_CTRL) begin
            ctrl_ff <= pwdata[1:0];
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        if (paddr == spp_pkg::OFS_CTRL) begin
            rd_mux = {30'h0000_0000, ctrl_ff};
        end else if (paddr == spp_pkg::OFS_STATUS) begin
            rd_mux = {15'h0000, fuse_lock, 2'h0, sel_ff, key_ff,
                      2'h0, try_ff, st_ff};
        end else if (fld_off[7:4] == 4'h0 && fld_off[1:0] == 2'h0) begin
            rd_mux = {8'h00, code_pad[fld_off[3:2]], 8'h00, val_pad[fld_off[3:2]]};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Read data held in a flop, loaded in the setup cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        end
    end

    assign pslverr = psel && penable && !rd_hit;
endmodule : spp_prog_core

// ### hdl/spp_pulse_det.sv
/*
 * Turns the classified supply level into one-cycle pulse events.
 * Assumes level_sym is synchronous to clk.
 */
`timescale 1ns/1ps
module spp_pulse_det #(
    parameter int BURN_CYC = spp_pkg::BURN_CYC_DFLT
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    input  wire logic [1:0] level_sym,
    spp_pulse_if.det        ev
);
    initial begin
        if (BURN_CYC < 1 || BURN_CYC >= (1 << spp_pkg::HCNT_W))
            $error("BURN_CYC out of range");
    end

    localparam logic [spp_pkg::HCNT_W-1:0] BURN_N = spp_pkg::HCNT_W'(BURN_CYC);

    logic [1:0]                 prev_ff;
    logic [spp_pkg::HCNT_W-1:0] hcnt_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_ff <= spp_pkg::SPP_LVL_LOW;
        end else if (clk_en) begin
            prev_ff <= level_sym;
        end
    end

    // Saturating length of the current top level pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hcnt_ff <= '0;
        end else if (clk_en) begin
            if (level_sym != spp_pkg::SPP_LVL_TOP)
                hcnt_ff <= '0;
            else if (hcnt_ff != BURN_N)
                hcnt_ff <= hcnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ev.mid_fall <= 1'b0;
            ev.top_end  <= 1'b0;
            ev.top_long <= 1'b0;
        end else if (clk_en) begin
            ev.mid_fall <= prev_ff == spp_pkg::SPP_LVL_MID
                           && level_sym == spp_pkg::SPP_LVL_LOW;
            ev.top_end  <= prev_ff == spp_pkg::SPP_LVL_TOP
                           && level_sym != spp_pkg::SPP_LVL_TOP;
            ev.top_long <= prev_ff == spp_pkg::SPP_LVL_TOP
                           && level_sym != spp_pkg::SPP_LVL_TOP
                           && hcnt_ff == BURN_N;
        end
    end
endmodule : spp_pulse_det

// ### hdl/spp_pulse_if.sv
/*
 * Pulse events passed from the level pulse detector to the core.
 * Assumes both ends sit in the core clock domain.
 */
`timescale 1ns/1ps
interface spp_pulse_if;
    logic mid_fall;
    logic top_end;
    logic top_long;

    modport det (output mid_fall, output top_end, output top_long);
    modport ctl (input mid_fall, input top_end, input top_long);
endinterface : spp_pulse_if

// ### testbench/spp_prog_checker.sv
/*
 * Port-level checks on the supply pulse programming core.
 * Assumes it is bound to spp_prog_core; clk_en drops only between top pulses.
 */
`timescale 1ns/1ps
module spp_prog_checker #(
    parameter int BURN_CYC = 20
) (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [1:0]  level_sym,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  fuse_sens,
    input wire logic [7:0]  fuse_duty,
    input wire logic        fuse_lock,
    input wire logic [7:0]  sens_dac,
    input wire logic [7:0]  duty_dac,
    input wire logic [7:0]  carr_dac,
    input wire logic        locked,
    input wire logic        burn_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------
    // Top pulse history
    // ------------------------------------------------------------
    logic [15:0] top_run_ff;
    logic [15:0] last_run_ff;
    logic [7:0]  top_age_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            top_run_ff  <= 16'h0000;
            last_run_ff <= 16'h0000;
            top_age_ff  <= 8'hFF;
        end else if (level_sym == 2'h2) begin
            top_run_ff <= top_run_ff + 16'h0001;
            top_age_ff <= 8'h00;
        end else begin
            if (top_run_ff != 16'h0000) begin
                last_run_ff <= top_run_ff;
            end
            top_run_ff <= 16'h0000;
            if (top_age_ff != 8'hFF) begin
                top_age_ff <= top_age_ff + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    burn_one_a: assert property (burn_req |=> !burn_req)
        else $error("burn request longer than one cycle");
    burn_long_a: assert property (burn_req |-> last_run_ff >= BURN_CYC && top_age_ff <= 8'h08)
        else $error("burn request without a recent long top pulse");
    lock_pin_a: assert property (locked == fuse_lock && !(locked && burn_req))
        else $error("lock pin wrong or burn while locked");
    lock_hold_a: assert property (fuse_lock && $past(fuse_lock) && $past(rst_b, 2)
        && $stable(fuse_sens) |-> $stable(sens_dac))
        else $error("sensitivity moved while locked");
    fuse_keep_a: assert property ($past(rst_b) && $stable(fuse_duty)
        |-> (duty_dac & fuse_duty) == fuse_duty)
        else $error("blown duty bit missing from value");
    carr_width_a: assert property (carr_dac[7:4] == 4'h0)
        else $error("carrier code beyond its field");
    duty_sat_a: assert property ($past(duty_dac) == 8'hFF |-> duty_dac == 8'hFF)
        else $error("duty code wrapped");
    apb_ready_a: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    apb_err_a: assert property (psel && penable && paddr > 8'h14
        |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    cover property (burn_req);
    cover property (duty_dac == 8'hFF);
    cover property (carr_dac == 8'h0F);
    cover property (pslverr);
endmodule : spp_prog_checker

bind spp_prog_core spp_prog_checker #(.BURN_CYC(BURN_CYC)) spp_prog_checker_i (
    .clk(clk), .rst_b(rst_b), .level_sym(level_sym), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fuse_sens(fuse_sens), .fuse_duty(fuse_duty),
    .fuse_lock(fuse_lock), .sens_dac(sens_dac), .duty_dac(duty_dac),
    .carr_dac(carr_dac), .locked(locked), .burn_req(burn_req)
);

// ### testbench/spp_prog_model.sv
/*
 * Behavioural pulse programmer driving the classified supply symbol.
 * Assumes every task is entered just after a rising clock edge.
 */
`timescale 1ns/1ps
module spp_prog_model #(
    parameter int GAP  = 20,
    parameter int BURN = 20
) (
    input  wire logic       clk,
    output logic      [1:0] level_sym
);
    initial level_sym = spp_pkg::SPP_LVL_LOW;

    // Every pulse ends with the low separation gap
    task automatic pulse(input logic [1:0] sym, input int len);
        level_sym <= sym;
        repeat (len) @(posedge clk);
        level_sym <= spp_pkg::SPP_LVL_LOW;
        repeat (GAP) @(posedge clk);
    endtask : pulse

    task automatic mids(input int n);
        repeat (n) pulse(spp_pkg::SPP_LVL_MID, 4);
    endtask : mids

    task automatic top(input logic burn);
        pulse(spp_pkg::SPP_LVL_TOP, burn ? BURN + 4 : 4);
    endtask : top

    task automatic key(input int n);
        mids(n);
        top(1'b0);
    endtask : key

    task automatic select(input int mode, input int reg_key);
        top(1'b0);
        key(mode);
        key(reg_key);
    endtask : select
endmodule : spp_prog_model

// ### testbench/tb_top.sv
/*
 * Self-checking bench for the supply pulse programming core.
 * Assumes spp_prog_model drives the supply; the fuse macro lives here.
 */
`timescale 1ns/1ps
module tb_top;
    localparam int BURN = 20;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        clk_en = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0]  fuse_sens = 8'h00;
    logic [7:0]  fuse_duty = 8'h00;
    logic [7:0]  fuse_carr = 8'h00;
    logic        fuse_lock = 1'b0;
    logic [1:0]  level_sym;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  sens_dac;
    logic [7:0]  duty_dac;
    logic [7:0]  carr_dac;
    logic        locked;
    logic        burn_req;
    logic [1:0]  burn_field;
    logic [7:0]  burn_mask;
    logic [1:0]  burn_f;
    logic [7:0]  burn_m;
    logic [31:0] rd;
    logic        er;
    int          err_total = 0;
    int          checks_done = 0;
    int          burn_cnt = 0;

    always #4 clk = ~clk;

    spp_prog_core #(.BURN_CYC(BURN)) spp_prog_core_i (
        .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .level_sym(level_sym),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fuse_sens(fuse_sens), .fuse_duty(fuse_duty), .fuse_carr(fuse_carr),
        .fuse_lock(fuse_lock), .sens_dac(sens_dac), .duty_dac(duty_dac),
        .carr_dac(carr_dac), .locked(locked), .burn_req(burn_req),
        .burn_field(burn_field), .burn_mask(burn_mask)
    );

    spp_prog_model #(.GAP(BURN), .BURN(BURN)) spp_prog_model_i (
        .clk(clk), .level_sym(level_sym)
    );

    // Fuse macro: blown bits never clear, not even on reset
    always @(posedge clk) begin
        if (burn_req === 1'b1) begin
            burn_cnt++;
            burn_f = burn_field;
            burn_m = burn_mask;
            case (burn_field)
                2'h0: fuse_sens <= fuse_sens | burn_mask;
                2'h1: fuse_duty <= fuse_duty | burn_mask;
                2'h2: fuse_carr <= fuse_carr | burn_mask;
                default: fuse_lock <= 1'b1;
            endcase
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic reset_dut;
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : reset_dut

    // Entered just after a rising edge; request held until ready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic sc_try;
        reset_dut();
        burn_cnt = 0;
        spp_prog_model_i.select(2, 1);
        spp_prog_model_i.mids(3);
        chk(sens_dac, 8'h03);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk({7'h00, rd[5]}, 8'h01);
        spp_prog_model_i.top(1'b0);
        spp_prog_model_i.key(2);
        spp_prog_model_i.key(2);
        spp_prog_model_i.mids(2);
        chk(duty_dac, 8'h02);
        chk(sens_dac, 8'h03);
        chk(8'(burn_cnt), 8'h00);
        reset_dut();
        chk(sens_dac, 8'h00);
        chk(duty_dac, 8'h00);
    endtask : sc_try

    task automatic sc_sat;
        reset_dut();
        spp_prog_model_i.select(2, 3);
        spp_prog_model_i.mids(17);
        chk(carr_dac, 8'h0F);
        spp_prog_model_i.top(1'b0);
        spp_prog_model_i.key(2);
        spp_prog_model_i.key(2);
        spp_prog_model_i.mids(256);
        chk(duty_dac, 8'hFF);
    endtask : sc_sat

    task automatic sc_apb;
        reset_dut();
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk({6'h00, rd[1:0]}, 8'h03);
        apb(1'b1, 8'h00, 32'h0000_0002);
        spp_prog_model_i.select(2, 3);
        spp_prog_model_i.mids(2);
        chk(carr_dac, 8'h00);
        apb(1'b1, 8'h00, 32'h0000_0003);
        spp_prog_model_i.select(2, 3);
        spp_prog_model_i.mids(5);
        clk_en <= 1'b0;
        spp_prog_model_i.mids(2);
        clk_en <= 1'b1;
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk(rd[23:16], 8'h05);
        chk(rd[7:0], 8'h05);
        chk(carr_dac, 8'h05);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk({7'h00, er}, 8'h01);
        chk(rd[7:0], 8'h00);
    endtask : sc_apb

    task automatic sc_blow;
        reset_dut();
        burn_cnt = 0;
        spp_prog_model_i.select(1, 2);
        spp_prog_model_i.mids(4);
        chk(duty_dac, 8'h04);
        spp_prog_model_i.top(1'b1);
        chk(8'(burn_cnt), 8'h01);
        chk({6'h00, burn_f}, 8'h01);
        chk(burn_m, 8'h04);
        reset_dut();
        chk(duty_dac, 8'h04);
        spp_prog_model_i.select(1, 2);
        spp_prog_model_i.mids(1);
        chk(duty_dac, 8'h05);
        reset_dut();
        chk(duty_dac, 8'h04);
        spp_prog_model_i.select(1, 6);
        spp_prog_model_i.mids(1);
        spp_prog_model_i.top(1'b1);
        chk({6'h00, burn_f}, 8'h03);
        reset_dut();
        chk({7'h00, locked}, 8'h01);
        spp_prog_model_i.select(2, 1);
        spp_prog_model_i.mids(2);
        chk(sens_dac, 8'h00);
    endtask : sc_blow

    initial begin
        sc_try();
        sc_sat();
        sc_apb();
        sc_blow();
        stop_test();
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        stop_test();
    end
endmodule : tb_top
